// file: hdl/map_fsm_pkg.sv
// constants, register map and state type for the principal switch map control
`default_nettype none
package map_fsm_pkg;
  localparam int unsigned NLINK     = 8;
  localparam int unsigned LINK_W    = 3;
  localparam int unsigned FLAG_W    = 8;
  // request type flag positions, one of them set per request
  localparam int unsigned F_MAP_UPD = 0;
  localparam int unsigned F_OVR_INC = 1;
  localparam int unsigned F_OVR_MAP = 2;
  localparam int unsigned F_PRINC   = 3;
  localparam int unsigned F_LINK_CH = 4;
  localparam int unsigned F_PROBLEM = 5;
  // reject reason and explanation codes, values arbitrary
  localparam logic [7:0] RSN_LOGICAL_ERROR = 8'h03;
  localparam logic [7:0] EXP_INVALID_DATA  = 8'h01;
  localparam logic [7:0] RSN_NONE          = 8'h00;
  // reply timeout: twice the error detect timeout
  localparam int unsigned CLK_MHZ                 = 125;
  localparam int unsigned ERROR_DETECT_TIMEOUT_US = 2000;
  localparam int unsigned TIMEOUT_CYCLES = 2 * ERROR_DETECT_TIMEOUT_US * CLK_MHZ;
  // apb byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INCARN = 8'h08;
  localparam logic [7:0] OFS_LINKF  = 8'h0c;
  localparam logic [7:0] OFS_NOTIFY = 8'h10;
  localparam logic [7:0] OFS_ISTAT  = 8'h14;
  localparam logic [7:0] OFS_IMASK  = 8'h18;
  // field positions
  localparam int unsigned LF_UPLINK  = 0;
  localparam int unsigned LF_REJECT  = 8;
  localparam int unsigned LF_TIMEOUT = 16;
  localparam int unsigned LF_PROBLEM = 24;
  localparam int unsigned ST_SUSP    = 0;
  localparam int unsigned ST_LOST    = 1;
  localparam int unsigned ST_BUSY    = 2;
  localparam int unsigned ST_VER     = 8;
  localparam int unsigned NIRQ       = 4;
  localparam int unsigned IRQ_REJECT = 0;
  localparam int unsigned IRQ_TMO    = 1;
  localparam int unsigned IRQ_RXRJT  = 2;
  localparam int unsigned IRQ_LOST   = 3;
  // reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [31:0] RST_INCARN = 32'h0000_0000;
  typedef enum logic [2:0] {
    st_idle, st_process, st_issue, st_wait, st_update, st_lost
  } state_t;
endpackage
`default_nettype wire

// file: hdl/reply_timer.sv
// reply timeout counter, restarted whenever requests are sent
`timescale 1ns/1ps
`default_nettype none
module reply_timer #(
  parameter int unsigned cycles = 1
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic restart,
  output logic      expired
);
  logic [31:0] count_reg;
  logic        run_reg;

  // expired stays high until the next restart so the fsm sees it as a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 32'h0000_0000;
      run_reg   <= 1'b0;
      expired   <= 1'b0;
    end else if (restart) begin
      count_reg <= 32'(cycles - 1);
      run_reg   <= 1'b1;
      expired   <= 1'b0;
    end else if (run_reg && count_reg == 32'h0000_0000) begin
      run_reg <= 1'b0;
      expired <= 1'b1;
    end else if (run_reg) begin
      count_reg <= count_reg - 32'h0000_0001;
    end
  end
endmodule // reply_timer
`default_nettype wire

// file: hdl/principal_switch_map_fsm.sv
// principal switch control: request processing, map send and map status update
// Operation
// RULE1: a link-change request is accepted, the map is updated and the fsm goes to map update.
// RULE2: a problem request is accepted, the problem is marked in the map, then map update follows.
// RULE3: map-update or override requests are rejected as logical error, invalid data, back to idle.
// RULE4: a principal-update request is accepted, uplink set, incarnation adopted, requests resent.
// RULE5: after processing, a changed map leads to map update, an unchanged one back to idle.
// RULE6: the send state sends on each active downlink, or does nothing and idles without one; after a principal update the code goes to st_lost instead.
// RULE7: sent requests use the payload, incarnation and type flags prepared beforehand.
// RULE8: a reject on a link sets that link's reject-detected flag before leaving the send state.
// RULE9: a timeout on a link sets that link's timeout-detected flag before leaving the send state.
// RULE10: all accepted returns to idle; any reject or a reply timeout goes to map update; after a principal update the code goes to st_lost in each case.
// RULE11: map update applies every local or reported link change to the map.
// RULE12: map update notifies every registered node port.
// RULE13: while suspended by command the map is not redistributed and the fsm idles.
// RULE14: otherwise incarnation is incremented, map-update flag set and the send state entered.
// RULE15: each request carries exactly one type flag at the fixed bit positions.
// RULE16: idle goes to processing on a request and to map update on a local port change.
// RULE17: per-link outstanding replies and one restartable timeout are evaluated together.
`timescale 1ns/1ps
`default_nettype none
module principal_switch_map_fsm #(
  parameter int unsigned timeout_cycles = map_fsm_pkg::TIMEOUT_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_req_valid,
  input  wire logic [7:0]  rx_req_flags,
  input  wire logic [2:0]  rx_req_link,
  input  wire logic [31:0] rx_req_incarnation,
  output logic             rx_req_ready,
  output logic             rsp_valid,
  output logic             rsp_accept,
  output logic [2:0]       rsp_link,
  output logic [7:0]       rsp_reason,
  output logic [7:0]       rsp_explain,
  output logic [7:0]       tx_req_valid,
  output logic [7:0]       tx_req_flags,
  output logic [31:0]      tx_req_incarnation,
  input  wire logic        reply_valid,
  input  wire logic [2:0]  reply_link,
  input  wire logic        reply_reject,
  input  wire logic        port_change,
  input  wire logic        suspend_map_update_cmd,
  input  wire logic        resume_map_update_cmd,
  output logic [7:0]       map_update_notify_cmd,
  output logic             irq
);
  map_fsm_pkg::state_t state_reg;
  logic [7:0]  flags_reg, link_active_reg, notify_mask_reg, downlinks;
  logic [2:0]  link_reg;
  logic [31:0] rx_inc_reg, incarnation_reg;
  logic [7:0]  uplink_reg, pend_reg, reject_det_reg, timeout_det_reg, problem_reg;
  logic [7:0]  map_version_reg;
  logic [3:0]  istat_reg, imask_reg, ev;
  logic        suspended_reg, lost_reg, change_pend_reg, any_reject_reg, expired;
  logic        one_flag, accepted, wr, hit, reply_hit;

  // exactly one defined flag set, reserved bits clear
  assign one_flag = (flags_reg[7:6] == 2'b00) && (flags_reg != 8'h00)
                    && ((flags_reg & (flags_reg - 8'h01)) == 8'h00); // see RULE15
  assign accepted = one_flag && (flags_reg[map_fsm_pkg::F_LINK_CH]
                    || flags_reg[map_fsm_pkg::F_PROBLEM] || flags_reg[map_fsm_pkg::F_PRINC]);
  assign downlinks    = link_active_reg & ~uplink_reg;
  assign reply_hit    = (state_reg == map_fsm_pkg::st_wait) && reply_valid
                        && pend_reg[reply_link];
  assign rx_req_ready = (state_reg == map_fsm_pkg::st_idle);
  assign wr           = psel && penable && pwrite;

  // main control flow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= map_fsm_pkg::st_idle;
    end else begin
      case (state_reg)
        map_fsm_pkg::st_idle: begin
          if (rx_req_valid) begin
            state_reg <= map_fsm_pkg::st_process; // see RULE16
          end else if (change_pend_reg) begin
            state_reg <= map_fsm_pkg::st_update; // see RULE16
          end
        end
        map_fsm_pkg::st_process: begin
          if (!accepted) begin
            state_reg <= map_fsm_pkg::st_idle; // see RULE3
          end else if (flags_reg[map_fsm_pkg::F_PRINC]) begin
            state_reg <= map_fsm_pkg::st_issue; // see RULE4
          end else begin
            state_reg <= map_fsm_pkg::st_update; // see RULE1 see RULE2 see RULE5
          end
        end
        map_fsm_pkg::st_issue: begin
          if (downlinks == 8'h00) begin
            state_reg <= lost_reg ? map_fsm_pkg::st_lost : map_fsm_pkg::st_idle; // see RULE6
          end else begin
            state_reg <= map_fsm_pkg::st_wait;
          end
        end
        map_fsm_pkg::st_wait: begin
          if (pend_reg == 8'h00) begin
            if (lost_reg) begin
              state_reg <= map_fsm_pkg::st_lost;
            end else begin
              state_reg <= any_reject_reg ? map_fsm_pkg::st_update
                                          : map_fsm_pkg::st_idle; // see RULE10
            end
          end else if (expired) begin
            state_reg <= lost_reg ? map_fsm_pkg::st_lost : map_fsm_pkg::st_update; // see RULE10
          end
        end
        map_fsm_pkg::st_update: begin
          state_reg <= suspended_reg ? map_fsm_pkg::st_idle
                                     : map_fsm_pkg::st_issue; // see RULE13 see RULE14
        end
        map_fsm_pkg::st_lost: state_reg <= map_fsm_pkg::st_lost;
        default: state_reg <= map_fsm_pkg::st_idle;
      endcase
    end
  end

  // latch an incoming request; only taken while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg  <= map_fsm_pkg::RST_BYTE;
      link_reg   <= 3'h0;
      rx_inc_reg <= map_fsm_pkg::RST_INCARN;
    end else if (rx_req_ready && rx_req_valid) begin
      flags_reg  <= rx_req_flags;
      link_reg   <= rx_req_link;
      rx_inc_reg <= rx_req_incarnation;
    end
  end

  // accept or reject answer, one pulse per processed request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid   <= 1'b0;
      rsp_accept  <= 1'b0;
      rsp_link    <= 3'h0;
      rsp_reason  <= map_fsm_pkg::RSN_NONE;
      rsp_explain <= map_fsm_pkg::RSN_NONE;
    end else begin
      rsp_valid   <= (state_reg == map_fsm_pkg::st_process);
      rsp_accept  <= accepted; // see RULE1 see RULE2 see RULE4
      rsp_link    <= link_reg;
      rsp_reason  <= accepted ? map_fsm_pkg::RSN_NONE : map_fsm_pkg::RSN_LOGICAL_ERROR; // see RULE3
      rsp_explain <= accepted ? map_fsm_pkg::RSN_NONE : map_fsm_pkg::EXP_INVALID_DATA;
    end
  end

  // incarnation, outgoing type flags and loss of the principal role
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      incarnation_reg <= map_fsm_pkg::RST_INCARN;
      tx_req_flags    <= map_fsm_pkg::RST_BYTE;
      lost_reg        <= 1'b0;
    end else if (state_reg == map_fsm_pkg::st_process && accepted
                 && flags_reg[map_fsm_pkg::F_PRINC]) begin
      incarnation_reg <= rx_inc_reg; // see RULE4
      tx_req_flags    <= 8'(1 << map_fsm_pkg::F_PRINC);
      lost_reg        <= 1'b1;
    end else if (state_reg == map_fsm_pkg::st_update && !suspended_reg) begin
      incarnation_reg <= incarnation_reg + 32'h0000_0001; // see RULE14
      tx_req_flags    <= 8'(1 << map_fsm_pkg::F_MAP_UPD);
    end
  end
  assign tx_req_incarnation = incarnation_reg; // see RULE7

  // send strobes, reject tracking and map version; notify goes with the version bump
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_req_valid          <= 8'h00;
      any_reject_reg        <= 1'b0;
      map_version_reg       <= 8'h00;
      map_update_notify_cmd <= 8'h00;
    end else begin
      tx_req_valid <= (state_reg == map_fsm_pkg::st_issue) ? downlinks : 8'h00; // see RULE6
      if (state_reg == map_fsm_pkg::st_issue) begin
        any_reject_reg <= 1'b0;
      end else if (reply_hit && reply_reject) begin
        any_reject_reg <= 1'b1;
      end
      if (state_reg == map_fsm_pkg::st_update) begin
        map_version_reg <= map_version_reg + 8'h01; // see RULE11
      end
      map_update_notify_cmd <= (state_reg == map_fsm_pkg::st_update)
                               ? notify_mask_reg : 8'h00; // see RULE12
    end
  end

  // one timer for all links; restarted in the cycle the requests go out
  reply_timer #(.cycles(timeout_cycles)) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (state_reg == map_fsm_pkg::st_issue), // see RULE17
    .expired (expired)
  );

  // per-link descriptor flags; a hardware set wins over a software clear
  for (genvar i = 0; i < map_fsm_pkg::NLINK; i++) begin : g_link
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend_reg[i]        <= 1'b0;
        uplink_reg[i]      <= 1'b0;
        reject_det_reg[i]  <= 1'b0;
        timeout_det_reg[i] <= 1'b0;
        problem_reg[i]     <= 1'b0;
      end else begin
        if (state_reg == map_fsm_pkg::st_issue) begin
          pend_reg[i] <= downlinks[i]; // see RULE17
        end else if ((reply_hit && reply_link == i) || expired) begin
          pend_reg[i] <= 1'b0;
        end
        if (state_reg == map_fsm_pkg::st_process && accepted && flags_reg[map_fsm_pkg::F_PRINC]) begin
          uplink_reg[i] <= (link_reg == i); // see RULE4
        end
        if (reply_hit && reply_link == i && reply_reject) begin
          reject_det_reg[i] <= 1'b1; // see RULE8
        end else if (wr && hit && paddr == map_fsm_pkg::OFS_LINKF
                     && pwdata[map_fsm_pkg::LF_REJECT + i]) begin
          reject_det_reg[i] <= 1'b0;
        end
        if (state_reg == map_fsm_pkg::st_wait && expired && pend_reg[i]) begin
          timeout_det_reg[i] <= 1'b1; // see RULE9
        end else if (wr && hit && paddr == map_fsm_pkg::OFS_LINKF
                     && pwdata[map_fsm_pkg::LF_TIMEOUT + i]) begin
          timeout_det_reg[i] <= 1'b0;
        end
        if (state_reg == map_fsm_pkg::st_process && accepted
            && flags_reg[map_fsm_pkg::F_PROBLEM] && link_reg == i) begin
          problem_reg[i] <= 1'b1; // see RULE2
        end else if (wr && hit && paddr == map_fsm_pkg::OFS_LINKF
                     && pwdata[map_fsm_pkg::LF_PROBLEM + i]) begin
          problem_reg[i] <= 1'b0;
        end
      end
    end
  end

  // suspend and resume; resume wins when both arrive together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspended_reg <= 1'b0;
    end else if (resume_map_update_cmd) begin
      suspended_reg <= 1'b0;
    end else if (suspend_map_update_cmd) begin
      suspended_reg <= 1'b1; // see RULE13
    end
  end

  // local port change waits in a pending bit so it is not lost while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_pend_reg <= 1'b0;
    end else if (port_change) begin
      change_pend_reg <= 1'b1;
    end else if (state_reg == map_fsm_pkg::st_update) begin
      change_pend_reg <= 1'b0; // see RULE11
    end
  end

  // interrupt events, sticky, write one to clear, set wins
  assign ev[map_fsm_pkg::IRQ_REJECT] = reply_hit && reply_reject;
  assign ev[map_fsm_pkg::IRQ_TMO]    = (state_reg == map_fsm_pkg::st_wait) && expired
                                       && (pend_reg != 8'h00);
  assign ev[map_fsm_pkg::IRQ_RXRJT]  = (state_reg == map_fsm_pkg::st_process) && !accepted;
  assign ev[map_fsm_pkg::IRQ_LOST]   = (state_reg == map_fsm_pkg::st_process) && accepted
                                       && flags_reg[map_fsm_pkg::F_PRINC];
  assign irq = |(istat_reg & imask_reg);

  // apb slave: zero wait states, unmapped offsets answer with pslverr
  assign hit = (paddr == map_fsm_pkg::OFS_CTRL) || (paddr == map_fsm_pkg::OFS_STATUS)
            || (paddr == map_fsm_pkg::OFS_INCARN) || (paddr == map_fsm_pkg::OFS_LINKF)
            || (paddr == map_fsm_pkg::OFS_NOTIFY) || (paddr == map_fsm_pkg::OFS_ISTAT)
            || (paddr == map_fsm_pkg::OFS_IMASK);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_active_reg <= map_fsm_pkg::RST_BYTE;
      notify_mask_reg <= map_fsm_pkg::RST_BYTE;
      imask_reg       <= 4'h0;
      istat_reg       <= 4'h0;
    end else begin
      if (wr && paddr == map_fsm_pkg::OFS_CTRL) begin
        link_active_reg <= pwdata[7:0];
      end
      if (wr && paddr == map_fsm_pkg::OFS_NOTIFY) begin
        notify_mask_reg <= pwdata[7:0];
      end
      if (wr && paddr == map_fsm_pkg::OFS_IMASK) begin
        imask_reg <= pwdata[3:0];
      end
      istat_reg <= (istat_reg & ~((wr && paddr == map_fsm_pkg::OFS_ISTAT) ? pwdata[3:0] : 4'h0))
                   | ev;
    end
  end

  // read data captured in the setup cycle, valid through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        map_fsm_pkg::OFS_CTRL:   prdata <= {24'h000000, link_active_reg};
        map_fsm_pkg::OFS_STATUS: prdata <= {16'h0000, map_version_reg, 5'h00,
                                   state_reg != map_fsm_pkg::st_idle, lost_reg, suspended_reg};
        map_fsm_pkg::OFS_INCARN: prdata <= incarnation_reg;
        map_fsm_pkg::OFS_LINKF:  prdata <= {problem_reg, timeout_det_reg, reject_det_reg,
                                   uplink_reg};
        map_fsm_pkg::OFS_NOTIFY: prdata <= {24'h000000, notify_mask_reg};
        map_fsm_pkg::OFS_ISTAT:  prdata <= {28'h0000000, istat_reg};
        map_fsm_pkg::OFS_IMASK:  prdata <= {28'h0000000, imask_reg};
        default:                 prdata <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  link_change_acc_a: assert property ((state_reg == map_fsm_pkg::st_process) // see RULE1
    && one_flag && flags_reg[map_fsm_pkg::F_LINK_CH]
    |=> rsp_valid && rsp_accept && state_reg == map_fsm_pkg::st_update)
    else $error("link change not accepted into map update");
  problem_mark_a: assert property ((state_reg == map_fsm_pkg::st_process) // see RULE2
    && one_flag && flags_reg[map_fsm_pkg::F_PROBLEM]
    |=> rsp_accept && problem_reg[$past(link_reg)] && state_reg == map_fsm_pkg::st_update)
    else $error("problem request not marked");
  bad_flag_rjt_a: assert property ((state_reg == map_fsm_pkg::st_process) // see RULE3
    && (flags_reg[2:0] != 3'h0)
    |=> rsp_valid && !rsp_accept && rsp_reason == map_fsm_pkg::RSN_LOGICAL_ERROR
        && rsp_explain == map_fsm_pkg::EXP_INVALID_DATA && state_reg == map_fsm_pkg::st_idle)
    else $error("map update request not rejected");
  principal_take_a: assert property ((state_reg == map_fsm_pkg::st_process) // see RULE4
    && one_flag && flags_reg[map_fsm_pkg::F_PRINC]
    |=> uplink_reg == 8'(1 << $past(link_reg)) && incarnation_reg == $past(rx_inc_reg)
        && tx_req_flags == 8'(1 << map_fsm_pkg::F_PRINC) && state_reg == map_fsm_pkg::st_issue)
    else $error("principal update not adopted");
  send_vector_a: assert property ((state_reg == map_fsm_pkg::st_issue) // see RULE6
    |=> tx_req_valid == $past(downlinks) && tx_req_flags == $past(tx_req_flags))
    else $error("send strobes wrong");
  reject_flag_a: assert property (reply_hit && reply_reject // see RULE8
    |=> reject_det_reg[$past(reply_link)] ##1 state_reg != map_fsm_pkg::st_idle)
    else $error("reject not recorded");
  timeout_flag_a: assert property ((state_reg == map_fsm_pkg::st_wait) && expired // see RULE9
    && pend_reg != 8'h00 && !lost_reg
    |=> ((timeout_det_reg & $past(pend_reg)) == $past(pend_reg))
        && state_reg == map_fsm_pkg::st_update)
    else $error("timeout not recorded");
  suspend_hold_a: assert property ((state_reg == map_fsm_pkg::st_update) // see RULE13
    && suspended_reg
    |=> state_reg == map_fsm_pkg::st_idle && incarnation_reg == $past(incarnation_reg))
    else $error("suspended map redistributed");
  incarn_step_a: assert property ((state_reg == map_fsm_pkg::st_update) // see RULE14
    && !suspended_reg
    |=> incarnation_reg == $past(incarnation_reg) + 32'h0000_0001
        && state_reg == map_fsm_pkg::st_issue ##1 tx_req_valid == $past(downlinks))
    else $error("incarnation not incremented");
  notify_nodes_a: assert property ((state_reg == map_fsm_pkg::st_update) // see RULE12
    |=> map_update_notify_cmd == $past(notify_mask_reg))
    else $error("registered nodes not notified");
  idle_take_a: assert property (rx_req_ready && rx_req_valid // see RULE16
    |=> state_reg == map_fsm_pkg::st_process ##1 rsp_valid)
    else $error("request not taken from idle");

  all_acc_c: cover property ((state_reg == map_fsm_pkg::st_wait) && pend_reg == 8'h00
    && !any_reject_reg ##1 state_reg == map_fsm_pkg::st_idle);
  timeout_c: cover property (ev[map_fsm_pkg::IRQ_TMO]);
  takeover_c: cover property (ev[map_fsm_pkg::IRQ_LOST] ##1 state_reg == map_fsm_pkg::st_issue);
endmodule // principal_switch_map_fsm
`default_nettype wire

// file: verif/switch_neighbor_model.sv
// neighbouring switches: one reply per request sent on an unmuted link
`timescale 1ns/1ps
`default_nettype none
module switch_neighbor_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] tx_req_valid,
  input  wire logic [7:0] rej_mask,
  input  wire logic [7:0] mute_mask,
  output logic            reply_valid,
  output logic [2:0]      reply_link,
  output logic            reply_reject
);
  logic [7:0] pend_reg;
  logic [2:0] last_reg;
  // one reply a cycle, muted links never answer so the sender times out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg     <= 8'h00;
      last_reg     <= 3'h0;
      reply_valid  <= 1'b0;
      reply_reject <= 1'b0;
    end else begin
      reply_valid <= 1'b0;
      pend_reg    <= pend_reg | tx_req_valid;
      for (int i = 0; i < 8; i++) begin
        if (pend_reg[i] && !mute_mask[i]) begin
          pend_reg     <= (pend_reg | tx_req_valid) & ~(8'h01 << i);
          reply_valid  <= 1'b1;
          reply_reject <= rej_mask[i];
          last_reg     <= i[2:0];
        end
      end
    end
  end
  // released link lines show the inverse of the last value, never a stale copy
  assign reply_link = reply_valid ? last_reg : ~last_reg;
endmodule // switch_neighbor_model
`default_nettype wire

// file: verif/principal_switch_map_fsm_tb_top.sv
// testbench for the principal switch map control
`timescale 1ns/1ps
`default_nettype none
module principal_switch_map_fsm_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic rx_req_valid = 1'b0, port_change = 1'b0, susp = 1'b0, resm = 1'b0;
  logic [7:0]  paddr = 8'h00, rx_req_flags = 8'h00, rej = 8'h00, mute = 8'h00;
  logic [7:0]  tx_req_valid, tx_req_flags, rsp_reason, rsp_explain, ntf_cmd, ntf, t_v, t_f;
  logic [31:0] pwdata = 32'h0, rx_req_incarnation = 32'h0, prdata, tx_req_incarnation, q, t_i;
  logic [2:0]  rx_req_link = 3'h0, rsp_link, reply_link;
  logic        pready, pslverr, rx_req_ready, rsp_valid, rsp_accept, reply_valid, reply_reject, irq;
  logic [19:0] rsp_seen;
  logic [7:0]  bad [5] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h30};
  int          failures = 0, n_tests = 0, n_tx = 0;
  always #4 pclk = ~pclk;
  principal_switch_map_fsm #(.timeout_cycles(20)) principal_switch_map_fsm_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_req_valid(rx_req_valid), .rx_req_flags(rx_req_flags), .rx_req_link(rx_req_link),
    .rx_req_incarnation(rx_req_incarnation), .rx_req_ready(rx_req_ready),
    .rsp_valid(rsp_valid), .rsp_accept(rsp_accept), .rsp_link(rsp_link),
    .rsp_reason(rsp_reason), .rsp_explain(rsp_explain), .tx_req_valid(tx_req_valid),
    .tx_req_flags(tx_req_flags), .tx_req_incarnation(tx_req_incarnation),
    .reply_valid(reply_valid), .reply_link(reply_link), .reply_reject(reply_reject),
    .port_change(port_change), .suspend_map_update_cmd(susp), .resume_map_update_cmd(resm),
    .map_update_notify_cmd(ntf_cmd), .irq(irq));
  switch_neighbor_model switch_neighbor_model_inst (.pclk(pclk), .presetn(presetn),
    .tx_req_valid(tx_req_valid), .rej_mask(rej), .mute_mask(mute), .reply_valid(reply_valid),
    .reply_link(reply_link), .reply_reject(reply_reject));
  // record the pulses so that scenarios can check them afterwards
  always @(posedge pclk) begin
    if (rsp_valid === 1'b1) rsp_seen = {rsp_link, rsp_accept, rsp_reason, rsp_explain};
    if (|tx_req_valid) begin
      n_tx++;
      t_v = tx_req_valid;
      t_f = tx_req_flags;
      t_i = tx_req_incarnation;
    end
    if (|ntf_cmd) ntf = ntf_cmd;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, read data and error taken at the completing edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic idle();
    while (rx_req_ready !== 1'b1) @(posedge pclk);
  endtask
  // source holds the request until the fsm takes it
  task automatic req(input logic [7:0] f, input logic [2:0] l, input logic [31:0] i);
    @(posedge pclk);
    rx_req_flags <= f; rx_req_link <= l; rx_req_incarnation <= i; rx_req_valid <= 1'b1;
    do @(posedge pclk); while (rx_req_ready !== 1'b1);
    rx_req_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // local port change, then suspend once the map is out so it is not resent
  task automatic kick();
    @(posedge pclk);
    resm <= 1'b1; port_change <= 1'b1;
    @(posedge pclk);
    resm <= 1'b0; port_change <= 1'b0;
    while (tx_req_valid === 8'h00) @(posedge pclk);
    susp <= 1'b1;
    @(posedge pclk);
    susp <= 1'b0;
    repeat (3) @(posedge pclk);
    idle();
  endtask
  task automatic conclude();
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc("incarn", map_fsm_pkg::OFS_INCARN, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, map_fsm_pkg::OFS_CTRL, 32'h6);
    apb(1'b1, map_fsm_pkg::OFS_NOTIFY, 32'h5);
    for (int k = 0; k < 5; k++) begin
      req(bad[k], 3'h3, 32'h0);
      chk("reject", {12'h0, 3'h3, 1'b0, map_fsm_pkg::RSN_LOGICAL_ERROR, 8'h01}, rsp_seen);
    end
    chk("sends", 32'h0, n_tx);
    rdc("istat", map_fsm_pkg::OFS_ISTAT, 32'h4);
    apb(1'b1, map_fsm_pkg::OFS_ISTAT, 32'hf);
    req(8'h10, 3'h1, 32'h0);
    idle();
    chk("accept", 32'h30000, rsp_seen);
    chk("notify", 32'h5, ntf);
    chk("tx links", 32'h6, t_v);
    chk("tx flags", 32'h1, t_f);
    chk("tx incarn", 32'h1, t_i);
    rdc("linkf", map_fsm_pkg::OFS_LINKF, 32'h0);
    apb(1'b1, map_fsm_pkg::OFS_IMASK, 32'h1);
    rej <= 8'h02;
    kick();
    rdc("linkf", map_fsm_pkg::OFS_LINKF, 32'h200);
    chk("irq", 32'h1, {31'h0, irq});
    chk("tx incarn", 32'h2, t_i);
    apb(1'b1, map_fsm_pkg::OFS_ISTAT, 32'hf);
    apb(1'b1, map_fsm_pkg::OFS_LINKF, 32'hffffff00);
    @(negedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    rej <= 8'h00; mute <= 8'h04;
    kick();
    rdc("linkf", map_fsm_pkg::OFS_LINKF, 32'h40000);
    rdc("istat", map_fsm_pkg::OFS_ISTAT, 32'h2);
    chk("irq", 32'h0, {31'h0, irq});
    mute <= 8'h00;
    apb(1'b1, map_fsm_pkg::OFS_LINKF, 32'hffffff00);
    req(8'h20, 3'h2, 32'h0);
    idle();
    chk("accept", 32'h50000, rsp_seen);
    chk("sends", 32'h3, n_tx);
    rdc("incarn", map_fsm_pkg::OFS_INCARN, 32'h3);
    req(8'h08, 3'h1, 32'h55);
    while (n_tx == 3) @(posedge pclk);
    repeat (4) @(posedge pclk);
    chk("accept", 32'h30000, rsp_seen);
    chk("tx links", 32'h4, t_v);
    chk("tx flags", 32'h8, t_f);
    chk("tx incarn", 32'h55, t_i);
    rdc("linkf", map_fsm_pkg::OFS_LINKF, 32'h04000002);
    rdc("status", map_fsm_pkg::OFS_STATUS, 32'h607);
    conclude();
  end
endmodule // principal_switch_map_fsm_tb_top
`default_nettype wire
